// File: common/lcd_rst_map.vh
// Constants for the reset, mode and trim sequencer.
// Assumes a 25 MHz pclk; included by the sequencer, the checker and the bench by bare name.
`ifndef LCD_RST_MAP_VH
`define LCD_RST_MAP_VH
// Register byte offsets
`define OFF_CTRL        12'h000
`define OFF_CMD         12'h004
`define OFF_STATUS      12'h008
`define OFF_NV_CTRL     12'h00C
`define OFF_CONTRAST    12'h010
`define OFF_VSET        12'h014
`define OFF_TRIM        12'h018
// Control register fields
`define CTRL_DISP_BIT   2
`define CTRL_INTVLCD    0
// Command register fields
`define CMD_SYSRST      0
`define CMD_NV_ERASE    1
`define CMD_NV_PROG     2
// Operating mode encodings
`define MODE_RESET      2'b00
`define MODE_SLEEP      2'b10
`define MODE_NORMAL     2'b11
// Reset values and trim voltage settings
`define CTRL_RST        32'h0000_0001
`define CONTRAST_RST    8'h40
`define READ_VSET       8'h02
`define PROG_VSET       8'h3E
`define NV_MASK_RST     8'h00
// Timing figures and counts at 25 MHz
`define CLK_HZ          25000000
`define POR_WAIT_US     5000
`define MODE_SETTLE_US  10
`define POR_CYCLES      ((`POR_WAIT_US * (`CLK_HZ / 1000000)))
`define MODE_DIV        ((`MODE_SETTLE_US * (`CLK_HZ / 1000000)) / 8)
`define NV_STEP_CYCLES  64
`define NV_TRIES        2'd3
`endif

// File: verilog/nv_cell_store.v
// Eight nonvolatile trim cells modelled as a register with registered read.
// Assumes the sequencer issues one operation at a time.
`timescale 1ns/10ps
module nv_cell_store #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             op_erase,
    input  wire             op_prog,
    input  wire             op_read,
    input  wire [WIDTH-1:0] mask,
    output reg  [WIDTH-1:0] rdata_r
);
    reg [WIDTH-1:0] cells_r;

    // Erase clears masked cells, program sets them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cells_r <= {WIDTH{1'b0}};
            rdata_r <= {WIDTH{1'b0}};
        end else begin
            if (op_erase)
                cells_r <= cells_r & ~mask;
            else if (op_prog)
                cells_r <= cells_r | mask;
            if (op_read)
                rdata_r <= cells_r;
        end
    end
endmodule

// File: verilog/lcd_reset_mode_nv_trim_ctrl.v
// Reset, operating mode and trim sequencing with an APB register file.
// Assumes APB master on pclk; reset_pin_n and voltage-ready flags are synchronous.
`timescale 1ns/10ps
`include "lcd_rst_map.vh"
// What this block does
// - After power-up hold reset for about five milliseconds, then start the trim read.
// - System reset starts on software command or while reset pin is low.
// - Reset sequence sets mode Reset and restores control register defaults.
// - Mode field encodes Reset 00, Sleep 10, Normal 11.
// - Reset and Sleep stop clock, drivers, pump; drain on; host always active.
// - Writing display enable moves mode to Sleep when clear, Normal when set.
// - Sleep and Normal changes land on internal clock edges; host waits ten microseconds.
// - Sleep keeps every user-written control value; only Reset restores defaults.
// - Drivers stay idle after leaving Sleep or Reset until voltages ready.
// - Commands are accepted in any order; erase and program only while the sequencer is idle.
// - Without internal drive voltage, drive node is not drained in reset.
// - Trim read runs after power-on or pin reset, never software reset.
// - Busy and success flags step 00, 10, 11, then 01 on trim read.
// - Program and erase use setting 3Eh; read uses setting 02h.
// - Failed program or erase retries twice more; third failure clears success.
// - Display-on ignored during trim operation; trim operation ignored while display on.
// - Trim offset subtracts low five bits when sign set, else adds.
module lcd_reset_mode_nv_trim_ctrl #(
    parameter POR_CYCLES  = `POR_CYCLES,
    parameter STEP_CYCLES = `NV_STEP_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        reset_pin_n,
    input  wire        vlcd_ready,
    input  wire        vbias_ready,
    input  wire        nv_verify_ok,
    output wire [1:0]  operating_mode_field,
    output wire        int_clock_en,
    output wire        pump_en,
    output wire        drain_en,
    output wire        drain_vlcd_en,
    output reg         common_driver_en,
    output reg         segment_driver_en,
    output reg  [7:0]  nv_voltage_setting,
    output reg  [7:0]  trimmed_contrast
);
    // Sequencer states, one-hot
    localparam ST_POR    = 6'b000001;
    localparam ST_IDLE   = 6'b000010;
    localparam ST_RBUSY  = 6'b000100;
    localparam ST_ROK    = 6'b001000;
    localparam ST_WOP    = 6'b010000;
    localparam ST_WCHK   = 6'b100000;

    reg [5:0]  state_r;
    reg [22:0] cnt_r;
    reg [1:0]  mode_r;
    reg [1:0]  mode_req_r;
    reg [31:0] ctrl_r;
    reg [7:0]  contrast_r;
    reg [7:0]  nv_mask_r;
    reg        nv_busy_flag;
    reg        nv_success_flag;
    reg        op_is_erase_r;
    reg [1:0]  tries_r;
    reg [7:0]  div_r;
    reg        pin_low_d_r;
    reg        sw_rst_r;
    wire [7:0] nonvolatile_trim;
    wire       wr_en;
    wire       rd_en;
    wire       mode_tick;
    wire       hw_rst;
    wire       disp_on;
    wire       nv_active;
    wire       cmd_wr;
    reg        op_erase;
    reg        op_prog;
    reg        op_read;
    reg [8:0]  trim_sum;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign cmd_wr  = wr_en && (paddr == `OFF_CMD);
    assign disp_on = ctrl_r[`CTRL_DISP_BIT];
    // Trim sequencer busy; refuses display-on writes
    assign nv_active = !(state_r == ST_IDLE) && !(state_r == ST_POR);
    // pin reset
    // Pin low held as reset; rising release triggers the trim read
    assign hw_rst = !reset_pin_n;
    // mode encoding
    // Register holds the two-bit code directly
    assign operating_mode_field = mode_r;
    assign int_clock_en = (mode_r == `MODE_NORMAL);
    assign pump_en      = (mode_r == `MODE_NORMAL);
    assign drain_en     = (mode_r != `MODE_NORMAL);
    assign drain_vlcd_en = drain_en && ctrl_r[`CTRL_INTVLCD];

    // Internal clock divider; Sleep and Normal only change on its edges
    assign mode_tick = (div_r == 8'h00);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_r <= 8'h00;
        else if (div_r == (`MODE_DIV - 1))
            div_r <= 8'h00;
        else
            div_r <= div_r + 8'h01;
    end

    // defaults on reset
    // Control registers; sleep never touches them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= `CTRL_RST;
            contrast_r <= `CONTRAST_RST;
            nv_mask_r  <= `NV_MASK_RST;
            sw_rst_r   <= 1'b0;
            mode_req_r <= `MODE_RESET;
        end else if (hw_rst || sw_rst_r || state_r == ST_POR) begin
            ctrl_r     <= `CTRL_RST;
            contrast_r <= `CONTRAST_RST;
            nv_mask_r  <= `NV_MASK_RST;
            sw_rst_r   <= 1'b0;
            mode_req_r <= `MODE_RESET;
        end else if (cmd_wr && pwdata[`CMD_SYSRST]) begin
            sw_rst_r <= 1'b1;
        end else if (wr_en) begin
            case (paddr)
                `OFF_CTRL: begin
                    if (pwdata[`CTRL_DISP_BIT] && nv_active)
                        ctrl_r <= {pwdata[31:3], disp_on, pwdata[1:0]};
                    else
                        ctrl_r <= pwdata;
                    if (!(pwdata[`CTRL_DISP_BIT] && nv_active))
                        mode_req_r <= pwdata[`CTRL_DISP_BIT] ? `MODE_NORMAL : `MODE_SLEEP;
                end
                `OFF_CONTRAST: contrast_r <= pwdata[7:0];
                `OFF_NV_CTRL:  nv_mask_r  <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // clock-edge mode update
    // Reset mode is immediate so draining starts at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mode_r <= `MODE_RESET;
        else if (hw_rst || sw_rst_r || state_r == ST_POR)
            mode_r <= `MODE_RESET;
        else if (mode_tick)
            mode_r <= mode_req_r;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            common_driver_en  <= 1'b0;
            segment_driver_en <= 1'b0;
        end else begin
            common_driver_en  <= (mode_r == `MODE_NORMAL) && vlcd_ready && vbias_ready;
            segment_driver_en <= (mode_r == `MODE_NORMAL) && vlcd_ready && vbias_ready;
        end
    end

    // Sequencer: power-on wait, trim read, program and erase with retry
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r         <= ST_POR;
            cnt_r           <= 23'd0;
            nv_busy_flag    <= 1'b0;
            nv_success_flag <= 1'b0;
            tries_r         <= 2'd0;
            op_is_erase_r   <= 1'b0;
            pin_low_d_r     <= 1'b0;
        end else begin
            pin_low_d_r <= hw_rst;
            case (state_r)
                ST_POR: begin
                    if (cnt_r == POR_CYCLES[22:0] - 23'd1) begin
                        cnt_r        <= 23'd0;
                        state_r      <= ST_RBUSY;
                        nv_busy_flag <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 23'd1;
                    end
                end
                ST_RBUSY: begin
                    if (cnt_r == STEP_CYCLES[22:0] - 23'd1) begin
                        cnt_r           <= 23'd0;
                        nv_success_flag <= 1'b1;
                        state_r         <= ST_ROK;
                    end else begin
                        cnt_r <= cnt_r + 23'd1;
                    end
                end
                ST_ROK: begin
                    if (cnt_r == STEP_CYCLES[22:0] - 23'd1) begin
                        cnt_r        <= 23'd0;
                        nv_busy_flag <= 1'b0;
                        state_r      <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 23'd1;
                    end
                end
                ST_IDLE: begin
                    if (pin_low_d_r && !hw_rst) begin
                        nv_busy_flag    <= 1'b0;
                        nv_success_flag <= 1'b0;
                        cnt_r           <= 23'd0;
                        state_r         <= ST_POR;
                    end else if (cmd_wr && !disp_on && !pwdata[`CMD_SYSRST] &&
                                 (pwdata[`CMD_NV_ERASE] || pwdata[`CMD_NV_PROG])) begin
                        op_is_erase_r   <= pwdata[`CMD_NV_ERASE];
                        tries_r         <= 2'd1;
                        nv_busy_flag    <= 1'b1;
                        nv_success_flag <= 1'b0;
                        cnt_r           <= 23'd0;
                        state_r         <= ST_WOP;
                    end
                end
                ST_WOP: begin
                    if (cnt_r == STEP_CYCLES[22:0] - 23'd1) begin
                        cnt_r   <= 23'd0;
                        state_r <= ST_WCHK;
                    end else begin
                        cnt_r <= cnt_r + 23'd1;
                    end
                end
                ST_WCHK: begin
                    if (nv_verify_ok) begin
                        nv_success_flag <= 1'b1;
                        nv_busy_flag    <= 1'b0;
                        state_r         <= ST_IDLE;
                    end else if (tries_r == `NV_TRIES) begin
                        nv_success_flag <= 1'b0;
                        nv_busy_flag    <= 1'b0;
                        state_r         <= ST_IDLE;
                    end else begin
                        tries_r <= tries_r + 2'd1;
                        state_r <= ST_WOP;
                    end
                end
                default: state_r <= ST_POR;
            endcase
            // A held pin restarts the power-on style sequence
            if (hw_rst) begin
                state_r         <= ST_POR;
                cnt_r           <= 23'd0;
                nv_busy_flag    <= 1'b0;
                nv_success_flag <= 1'b0;
            end
        end
    end

    // Cell strobes on the last cycle of each operation
    always @* begin
        op_read  = (state_r == ST_RBUSY) && (cnt_r == STEP_CYCLES[22:0] - 23'd1);
        op_erase = (state_r == ST_WOP) && op_is_erase_r &&
                   (cnt_r == STEP_CYCLES[22:0] - 23'd1);
        op_prog  = (state_r == ST_WOP) && !op_is_erase_r &&
                   (cnt_r == STEP_CYCLES[22:0] - 23'd1);
    end

    nv_cell_store #(
        .WIDTH (8)
    ) u_cells (
        .pclk     (pclk),
        .presetn  (presetn),
        .op_erase (op_erase),
        .op_prog  (op_prog),
        .op_read  (op_read),
        .mask     (nv_mask_r),
        .rdata_r  (nonvolatile_trim)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            nv_voltage_setting <= `READ_VSET;
        else if (state_r == ST_WOP || state_r == ST_WCHK)
            nv_voltage_setting <= `PROG_VSET;
        else
            nv_voltage_setting <= `READ_VSET;
    end

    // signed trim offset, saturated to keep contrast in range
    always @* begin
        if (nonvolatile_trim[5])
            trim_sum = {1'b0, contrast_r} - {4'h0, nonvolatile_trim[4:0]};
        else
            trim_sum = {1'b0, contrast_r} + {4'h0, nonvolatile_trim[4:0]};
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            trimmed_contrast <= 8'h00;
        else if (trim_sum[8])
            trimmed_contrast <= nonvolatile_trim[5] ? 8'h00 : 8'hFF;
        else
            trimmed_contrast <= trim_sum[7:0];
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                `OFF_CTRL:     prdata <= ctrl_r;
                `OFF_STATUS:   prdata <= {28'h0, nv_busy_flag, nv_success_flag, mode_r};
                `OFF_NV_CTRL:  prdata <= {24'h0, nv_mask_r};
                `OFF_CONTRAST: prdata <= {24'h0, contrast_r};
                `OFF_VSET:     prdata <= {24'h0, nv_voltage_setting};
                `OFF_TRIM:     prdata <= {24'h0, nonvolatile_trim};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// File: sim/lcd_ctrl_chk_sva.sv
// Checker for the mode, driver and trim voltage outputs of the sequencer.
// Sees only the top module ports; bound to every instance of it below.
`timescale 1ns/10ps
`include "lcd_rst_map.vh"
module lcd_ctrl_chk (
    input wire       pclk,
    input wire       presetn,
    input wire       reset_pin_n,
    input wire       vlcd_ready,
    input wire       vbias_ready,
    input wire [1:0] operating_mode_field,
    input wire       int_clock_en,
    input wire       pump_en,
    input wire       drain_en,
    input wire       drain_vlcd_en,
    input wire       common_driver_en,
    input wire       segment_driver_en,
    input wire [7:0] nv_voltage_setting
);
    wire run = operating_mode_field == `MODE_NORMAL;
    wire ok  = run && vlcd_ready && vbias_ready;
    // One clock domain, so one default clock and disable
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_MODE_CODE: assert property (operating_mode_field != 2'b01)
        else $error("mode field holds unused code");
    AST_RUN_EN: assert property ((int_clock_en == run) && (pump_en == run))
        else $error("clock or pump enable disagrees with mode");
    AST_DRAIN: assert property (drain_en == !run)
        else $error("drain enable disagrees with mode");
    AST_DRAIN_VLCD: assert property (drain_vlcd_en |-> drain_en)
        else $error("drive node drained outside drain mode");
    AST_PIN_RST: assert property (!reset_pin_n |=> operating_mode_field == `MODE_RESET)
        else $error("low reset pin left mode outside reset");
    AST_DRV_WAIT: assert property (common_driver_en |-> $past(ok))
        else $error("drivers on before voltages ready");
    AST_DRV_ON: assert property (ok ##1 ok |-> common_driver_en)
        else $error("drivers idle with voltages ready");
    AST_SEG_COM: assert property (segment_driver_en == common_driver_en)
        else $error("segment and common drivers differ");
    AST_NV_SET: assert property (nv_voltage_setting inside {`READ_VSET, `PROG_VSET})
        else $error("trim voltage setting out of set");
    // Main scenarios reached
    COV_NORMAL: cover property ($rose(common_driver_en));
    COV_SLEEP: cover property (operating_mode_field == `MODE_SLEEP);
    COV_PROG: cover property (nv_voltage_setting == `PROG_VSET);
endmodule
bind lcd_reset_mode_nv_trim_ctrl lcd_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn),
    .reset_pin_n(reset_pin_n), .vlcd_ready(vlcd_ready), .vbias_ready(vbias_ready),
    .operating_mode_field(operating_mode_field), .int_clock_en(int_clock_en),
    .pump_en(pump_en), .drain_en(drain_en), .drain_vlcd_en(drain_vlcd_en),
    .common_driver_en(common_driver_en), .segment_driver_en(segment_driver_en),
    .nv_voltage_setting(nv_voltage_setting));

// File: sim/lcd_analog_side.sv
// Analog side model: drive and bias ready flags, trim cell verify result.
// Assumes one clock; fail_verify is raised by the bench only on purpose.
`timescale 1ns/10ps
module lcd_analog_side #(
    parameter RAMP = 12
) (
    input  wire pclk,
    input  wire presetn,
    input  wire pump_en,
    input  wire fail_verify,
    output wire vlcd_ready,
    output wire vbias_ready,
    output wire nv_verify_ok
);
    integer cnt;
    // ramp before ready
    // Voltages build only while the pump runs; bias lags drive a little
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
        end else if (!pump_en) begin
            cnt <= 0;
        end else if (cnt < RAMP + 3) begin
            cnt <= cnt + 1;
        end
    end
    assign vlcd_ready  = cnt >= RAMP;
    assign vbias_ready = cnt >= RAMP + 2;
    assign nv_verify_ok = !fail_verify;
endmodule

// File: sim/lcd_reset_mode_nv_trim_ctrl_tb.sv
// Self-checking bench: APB host and analog side model around the sequencer.
// Assumes short POR and step counts below; the checker is bound separately.
`timescale 1ns/10ps
`include "lcd_rst_map.vh"
module lcd_reset_mode_nv_trim_ctrl_tb;
    localparam POR  = 40;
    localparam STEP = 16;
    reg         pclk, presetn, psel, penable, pwrite, reset_pin_n, nv_fail;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    reg  [1:0]  q[$];
    wire [31:0] prdata;
    wire [7:0]  nv_voltage_setting, trimmed_contrast;
    wire [1:0]  operating_mode_field;
    wire        pready, pslverr, vlcd_ready, vbias_ready, nv_verify_ok, int_clock_en;
    wire        pump_en, drain_en, drain_vlcd_en, common_driver_en, segment_driver_en;
    integer     err_count, checks, seed, m_ctrl, m_contrast, m_trim, i, n;
    lcd_reset_mode_nv_trim_ctrl #(.POR_CYCLES(POR), .STEP_CYCLES(STEP))
        u_lcd_reset_mode_nv_trim_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
        .vlcd_ready(vlcd_ready), .vbias_ready(vbias_ready), .nv_verify_ok(nv_verify_ok),
        .operating_mode_field(operating_mode_field), .int_clock_en(int_clock_en),
        .pump_en(pump_en), .drain_en(drain_en), .drain_vlcd_en(drain_vlcd_en),
        .common_driver_en(common_driver_en), .segment_driver_en(segment_driver_en),
        .nv_voltage_setting(nv_voltage_setting), .trimmed_contrast(trimmed_contrast));
    lcd_analog_side u_lcd_analog_side (.pclk(pclk), .presetn(presetn), .pump_en(pump_en),
        .fail_verify(nv_fail), .vlcd_ready(vlcd_ready), .vbias_ready(vbias_ready),
        .nv_verify_ok(nv_verify_ok));
    // Compare and count
    task chk(input [31:0] exp, input [31:0] got, input [8*8-1:0] what);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("mismatch %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel   <= 1'b1;
            pwrite <= w;
            paddr  <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            // Only the watchdog ends a wait for pready
            while (pready !== 1'b1)
                @(posedge pclk);
            rd = prdata;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Model of what a read returns
    function [31:0] exp_rd(input [11:0] a);
        begin
            case (a)
                `OFF_CTRL: exp_rd = m_ctrl;
                `OFF_CONTRAST: exp_rd = m_contrast;
                `OFF_VSET: exp_rd = {24'h0, `READ_VSET};
                `OFF_TRIM: exp_rd = m_trim;
                default: exp_rd = 32'h0;
            endcase
        end
    endfunction
    task rchk(input [11:0] a);
        begin
            apb(1'b0, a, 32'h0);
            chk(exp_rd(a), rd, "rdata");
            chk(0, pslverr, "slverr");
        end
    endtask
    // Sleep and Normal changes land on a divider tick, so wait a bounded span
    task wait_mode(input [1:0] m);
        begin
            n = 0;
            while (operating_mode_field !== m && n < 400) begin
                n = n + 1;
                @(posedge pclk);
            end
            chk({30'h0, m}, {30'h0, operating_mode_field}, "mode");
        end
    endtask
    // Poll status until busy drops; bounded so a stuck flag cannot hang
    task wait_idle;
        begin
            n = 0;
            rd = 32'hF;
            while (rd[3] !== 1'b0 && n < 100) begin
                n = n + 1;
                apb(1'b0, `OFF_STATUS, 32'h0);
            end
        end
    endtask
    // Record each distinct busy/success pair until ready is seen
    task trim_seq;
        begin
            q.delete();
            for (i = 0; i < 300 && !(q.size() > 1 && q[$] === 2'b01); i = i + 1) begin
                apb(1'b0, `OFF_STATUS, 32'h0);
                if (q.size() == 0 || q[$] !== rd[3:2])
                    q.push_back(rd[3:2]);
            end
            chk(4, q.size(), "steps");
            for (i = 0; i < 4 && i < q.size(); i = i + 1)
                chk((32'h2D >> (6 - 2 * i)) & 32'h3, {30'h0, q[i]}, "pair");
        end
    endtask
    task stop_test;
        begin
            $display("errors %0d checks %0d", err_count, checks);
            if (err_count == 0 && checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Free-running bench clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Watchdog well beyond the expected run length
    initial begin
        #(40 * 30000);
        err_count = err_count + 1;
        stop_test;
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, presetn, nv_fail} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        reset_pin_n = 1'b1;
        {err_count, checks, n, m_trim} = 0;
        seed = 32'h1CC2;
        m_ctrl = 1;
        m_contrast = 8'h40;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(`MODE_RESET, operating_mode_field, "mode");
        trim_seq;
        apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
        rchk(`OFF_CTRL);
        rchk(`OFF_CONTRAST);
        rchk(`OFF_VSET);
        rchk(12'h01C);
        m_contrast = $random(seed) & 8'hFF;
        m_ctrl = 5;
        apb(1'b1, `OFF_CONTRAST, m_contrast);
        apb(1'b1, `OFF_CTRL, m_ctrl);
        wait_mode(`MODE_NORMAL);
        repeat (30) @(posedge pclk);
        chk(1, common_driver_en & int_clock_en & !drain_en, "normal");
        apb(1'b1, `OFF_CMD, 32'h2);
        repeat (2 * STEP) @(posedge pclk);
        chk(`READ_VSET, nv_voltage_setting, "vset");
        m_ctrl = 0;
        apb(1'b1, `OFF_CTRL, 32'h0);
        wait_mode(`MODE_SLEEP);
        chk(2, {drain_en, drain_vlcd_en}, "drain");
        rchk(`OFF_CONTRAST);
        nv_fail <= 1'b1;
        apb(1'b1, `OFF_NV_CTRL, 32'hFF);
        apb(1'b1, `OFF_CMD, 32'h2);
        n = 0;
        for (i = 0; i < 400 && (n == 0 || nv_voltage_setting === `PROG_VSET); i = i + 1) begin
            if (nv_voltage_setting === `PROG_VSET)
                n = n + 1;
            @(posedge pclk);
        end
        chk(1, n >= 3 * STEP - 2 && n <= 4 * STEP, "tries");
        wait_idle;
        chk(0, rd[2], "success");
        nv_fail <= 1'b0;
        m_trim = 32'h1 << ($unsigned($random(seed)) % 8);
        apb(1'b1, `OFF_NV_CTRL, m_trim);
        apb(1'b1, `OFF_CMD, 32'h4);
        apb(1'b1, `OFF_CTRL, 32'h4);
        wait_idle;
        chk(1, rd[2], "success");
        chk(`MODE_SLEEP, operating_mode_field, "mode");
        apb(1'b1, `OFF_CMD, 32'h1);
        wait_mode(`MODE_RESET);
        m_ctrl = 1;
        m_contrast = 8'h40;
        rchk(`OFF_CONTRAST);
        n = 0;
        for (i = 0; i < 20; i = i + 1) begin
            apb(1'b0, `OFF_STATUS, 32'h0);
            n = n | rd[3];
        end
        chk(0, n, "busy");
        reset_pin_n <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(`MODE_RESET, operating_mode_field, "mode");
        reset_pin_n <= 1'b1;
        trim_seq;
        rchk(`OFF_CTRL);
        rchk(`OFF_TRIM);
        // Programmed cell read back after pin reset; contrast is at its default
        chk((m_trim & 32) ? 64 - (m_trim & 31) : 64 + (m_trim & 31), trimmed_contrast, "trim");
        stop_test;
    end
endmodule
